// File: design/ral_map.vh
// Register map, level tables and timing constants of the record level loop
`ifndef RAL_MAP_VH
`define RAL_MAP_VH

// Extended timing registers, page zero indices
`define RAL_OFS_R_ATK     8'h67
`define RAL_OFS_R_DEC     8'h68
`define RAL_OFS_L_ATK     8'h69
`define RAL_OFS_L_DEC     8'h6A
`define RAL_REG_RST       8'h00
`define RAL_RD_NONE       8'h00

// Target levels as average amplitude, full scale 32768
`define RAL_TGT_0         16'h43F8
`define RAL_TGT_1         16'h32F5
`define RAL_TGT_2         16'h287A
`define RAL_TGT_3         16'h2027
`define RAL_TGT_4         16'h198A
`define RAL_TGT_5         16'h1215
`define RAL_TGT_6         16'h0CCD
`define RAL_TGT_7         16'h0814

// Noise threshold: -30 dB, one 6 dB step per code down to -90 dB
`define RAL_NOISE_TOP     16'h0400
`define RAL_NOISE_LAST    4'hA

// Attack in ms, decay in 10 ms units, spread over the 8-bit code
`define RAL_ATK_MIN_MS    32'h0000_0007
`define RAL_ATK_SPAN_MS   32'h0000_0579
`define RAL_DEC_MIN_U     32'h0000_0005
`define RAL_DEC_SPAN_U    32'h0000_08BB
`define RAL_DEC_UNIT_MS   32'h0000_000A
`define RAL_CODE_FULL     32'h0000_00FF
// Gain steps of 0.5 dB making up one time constant
`define RAL_STEP_DIV      32'h0000_000C
// Divider code 0 is ratio 1; ratio counted in half units
`define RAL_HALF_BASE     24'h00_0002
`define RAL_GAIN_ZERO     7'h00
`define RAL_GAIN_TOP      7'h77

`endif

// File: design/ral_abs_avg.v
// Running average of the absolute value of one channel's samples
module ral_abs_avg #(
  parameter W     = 16,
  parameter SHIFT = 6
) (
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire         i_valid,
  input  wire [W-1:0] i_sample,
  output wire [W-1:0] o_avg
);

  reg  [W+SHIFT-1:0] acc_reg;
  wire [W-1:0]       mag;
  wire [W+SHIFT-1:0] acc_next;

  // Magnitude of a two's complement sample, most negative fits unsigned
  assign mag = i_sample[W-1] ? (~i_sample + {{(W-1){1'b0}}, 1'b1})
                             : i_sample;
  // Leaky integrator, gain of 2^SHIFT in steady state
  assign acc_next = acc_reg - (acc_reg >> SHIFT)
                  + {{SHIFT{1'b0}}, mag};
  assign o_avg = acc_reg[W+SHIFT-1:SHIFT];

  // Update once per converted sample
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_reg <= {(W+SHIFT){1'b0}};
    end else if (i_valid) begin
      acc_reg <= acc_next;
    end
  end

endmodule

// File: design/ral_auto_level.v
// Stereo record auto level loop with its extended timing registers
`include "ral_map.vh"

//Contract
// - With loop enabled adjust amplifier gain; disabled, gain request untouched.
// - Level estimate is the running average of absolute samples.
// - Left and right loops are separate, sharing no state.
// - Eight target levels from -5.5 dB to -24 dB full scale.
// - Above target gain falls at attack rate; below it rises at decay.
// - Attack time programmable from 7 ms to 1408 ms per channel.
// - Extended attack registers: right at 103, left at 105.
// - Decay time programmable from 0.05 s to 22.4 s per channel.
// - Extended decay registers: right at 104, left at 106.
// - Fixed-length counter bounds decay, so the limit scales with divider.
// - Below noise threshold step gain to 0 dB per sample, flag it.
// - Gain held at 0 dB until level rises above threshold again.
// - Noise threshold -30 dB to -90 dB; gate can be switched off.
// - Gate decision has debounce and hysteresis.
// - Loop gain capped at programmable maximum, 0 to 59.5 dB; the 7-bit cap field is not limited and reaches 63.5 dB.
// - Timing derives from reference rate setting; double rate not compensated.
// - Applied gain moves one 0.5 dB step per one or two samples.
// - Applied gain starts muted after reset.
module ral_auto_level #(
  parameter AVG_SHIFT   = 6,
  parameter DEC_CNT_MAX = 16000,
  parameter DEC_CNT_W   = 16
) (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  output wire [7:0]  o_reg_rdata,
  input  wire        i_adc_valid,
  input  wire [15:0] i_adc_left,
  input  wire [15:0] i_adc_right,
  input  wire [1:0]  i_loop_enable,
  input  wire [5:0]  i_target_sel,
  input  wire [13:0] i_max_gain,
  input  wire [7:0]  i_noise_sel,
  input  wire [1:0]  i_gate_off,
  input  wire [7:0]  i_debounce,
  input  wire [3:0]  i_hyst_sel,
  input  wire        i_step_two,
  input  wire [5:0]  i_reference_sample_rate,
  input  wire [3:0]  i_adc_rate_divider,
  output wire [13:0] o_gain_req,
  output wire [13:0] o_gain_applied,
  output wire [1:0]  o_gain_muted,
  output wire [1:0]  o_gain_done,
  output wire [1:0]  o_noise_flag,
  output wire [1:0]  o_sat_flag
);

  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_GATE = 3'b100;
  reg [7:0] right_attack_extended_reg;
  reg [7:0] right_decay_extended_reg;
  reg [7:0] left_attack_extended_reg;
  reg [7:0] left_decay_extended_reg;
  reg [7:0] rdata_reg;
  // Average level that one target code asks for
  function [15:0] target_level;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    target_level = `RAL_TGT_0;
        3'h1:    target_level = `RAL_TGT_1;
        3'h2:    target_level = `RAL_TGT_2;
        3'h3:    target_level = `RAL_TGT_3;
        3'h4:    target_level = `RAL_TGT_4;
        3'h5:    target_level = `RAL_TGT_5;
        3'h6:    target_level = `RAL_TGT_6;
        default: target_level = `RAL_TGT_7;
      endcase
    end
  endfunction

  // Noise threshold, codes past the last one stay at -90 dB
  function [15:0] noise_level;
    input [3:0] sel;
    begin
      noise_level = `RAL_NOISE_TOP >>
                    ((sel > `RAL_NOISE_LAST) ? `RAL_NOISE_LAST : sel);
    end
  endfunction

  // Half reference periods between two gain steps
  function [23:0] step_period;
    input [7:0]  code;
    input [5:0]  fs_khz;
    input        decay;
    reg   [31:0] ms;
    begin
      if (decay) begin
        ms = (`RAL_DEC_MIN_U + ({24'h00_0000, code} * `RAL_DEC_SPAN_U)
             / `RAL_CODE_FULL) * `RAL_DEC_UNIT_MS;
      end else begin
        ms = `RAL_ATK_MIN_MS + ({24'h00_0000, code} * `RAL_ATK_SPAN_MS)
             / `RAL_CODE_FULL;
      end
      ms = (ms * {26'h000_0000, fs_khz} * 32'h0000_0002) / `RAL_STEP_DIV;
      step_period = ms[23:0];
    end
  endfunction

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      right_attack_extended_reg <= `RAL_REG_RST;
      right_decay_extended_reg  <= `RAL_REG_RST;
      left_attack_extended_reg  <= `RAL_REG_RST;
      left_decay_extended_reg   <= `RAL_REG_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `RAL_OFS_R_ATK) begin
        right_attack_extended_reg <= i_reg_wdata;
      end else if (i_reg_addr == `RAL_OFS_R_DEC) begin
        right_decay_extended_reg <= i_reg_wdata;
      end else if (i_reg_addr == `RAL_OFS_L_ATK) begin
        left_attack_extended_reg <= i_reg_wdata;
      end else if (i_reg_addr == `RAL_OFS_L_DEC) begin
        left_decay_extended_reg <= i_reg_wdata;
      end
    end
  end

  // Read data follows the address one clock later, unmapped reads zero
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= `RAL_RD_NONE;
    end else if (i_reg_addr == `RAL_OFS_R_ATK) begin
      rdata_reg <= right_attack_extended_reg;
    end else if (i_reg_addr == `RAL_OFS_R_DEC) begin
      rdata_reg <= right_decay_extended_reg;
    end else if (i_reg_addr == `RAL_OFS_L_ATK) begin
      rdata_reg <= left_attack_extended_reg;
    end else if (i_reg_addr == `RAL_OFS_L_DEC) begin
      rdata_reg <= left_decay_extended_reg;
    end else begin
      rdata_reg <= `RAL_RD_NONE;
    end
  end

  assign o_reg_rdata = rdata_reg;

  // Divider ratio in half units, shared timing input of both loops
  wire [23:0] half_ratio = {20'h0_0000, i_adc_rate_divider} + `RAL_HALF_BASE;

  // one loop per channel, index 0 left
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [15:0] sample   = (ch == 0) ? i_adc_left : i_adc_right;
      wire [7:0]  atk_code = (ch == 0) ? left_attack_extended_reg
                                       : right_attack_extended_reg;
      wire [7:0]  dec_code = (ch == 0) ? left_decay_extended_reg
                                       : right_decay_extended_reg;
      wire        en       = i_loop_enable[ch];
      wire [6:0]  max_gain = i_max_gain[7*ch +: 7];
      wire [3:0]  deb_lim  = i_debounce[4*ch +: 4];
      wire [15:0] avg, target, thr, rel;
      wire [23:0] atk_per, dec_per, atk_sum, dec_sum;
      wire        below_gate;
      reg [2:0]           state_reg;
      reg [6:0]           req_reg, app_reg;
      reg                 mute_reg, done_reg, noise_reg, sat_reg, half_reg;
      reg [3:0]           deb_reg;
      reg [23:0]          atk_acc_reg, dec_acc_reg;
      reg [DEC_CNT_W-1:0] dec_cnt_reg;
      ral_abs_avg #(
        .W     (16),
        .SHIFT (AVG_SHIFT)
      ) u_avg (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_valid   (i_adc_valid),
        .i_sample  (sample),
        .o_avg     (avg)
      );
      assign target = target_level(i_target_sel[3*ch +: 3]);
      assign thr = noise_level(i_noise_sel[4*ch +: 4]);
      // hysteresis, release 0 to 18 dB above threshold
      assign rel = thr << i_hyst_sel[2*ch +: 2];
      assign atk_per = step_period(atk_code, i_reference_sample_rate, 1'b0);
      assign dec_per = step_period(dec_code, i_reference_sample_rate, 1'b1);
      // time runs in half reference periods per sample
      assign atk_sum = atk_acc_reg + half_ratio;
      assign dec_sum = dec_acc_reg + half_ratio;
      assign below_gate = !i_gate_off[ch] && (avg < thr);
      // loop state, advanced once per sample
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          state_reg   <= ST_OFF;
          req_reg     <= `RAL_GAIN_ZERO;
          noise_reg   <= 1'b0;
          sat_reg     <= 1'b0;
          deb_reg     <= 4'h0;
          atk_acc_reg <= 24'h00_0000;
          dec_acc_reg <= 24'h00_0000;
          dec_cnt_reg <= {DEC_CNT_W{1'b0}};
        end else if (i_adc_valid && !en) begin
          // disabled loop parks, gain request untouched
          state_reg <= ST_OFF;
          noise_reg <= 1'b0;
          sat_reg   <= 1'b0;
          deb_reg   <= 4'h0;
        end else if (i_adc_valid) begin
          case (state_reg)
            ST_OFF: begin
              state_reg <= ST_RUN;
            end
            ST_RUN: begin
              if (below_gate && deb_reg >= deb_lim) begin
                state_reg <= ST_GATE;
                noise_reg <= 1'b1;
                deb_reg   <= 4'h0;
              end else begin
                deb_reg <= below_gate ? deb_reg + 4'h1 : 4'h0;
              end
              // cap lowered below the present request
              if (req_reg > max_gain) begin
                req_reg     <= req_reg - 7'h01;
                atk_acc_reg <= 24'h00_0000;
                dec_acc_reg <= 24'h00_0000;
                dec_cnt_reg <= {DEC_CNT_W{1'b0}};
                sat_reg     <= 1'b0;
              end else if (avg > target) begin
                dec_acc_reg <= 24'h00_0000;
                dec_cnt_reg <= {DEC_CNT_W{1'b0}};
                sat_reg     <= 1'b0;
                if (atk_sum >= atk_per) begin
                  atk_acc_reg <= 24'h00_0000;
                  if (req_reg != `RAL_GAIN_ZERO) begin
                    req_reg <= req_reg - 7'h01;
                  end
                end else begin
                  atk_acc_reg <= atk_sum;
                end
              end else if (avg < target) begin
                atk_acc_reg <= 24'h00_0000;
                sat_reg     <= (req_reg == max_gain);
                if (dec_sum >= dec_per ||
                    dec_cnt_reg == DEC_CNT_MAX[DEC_CNT_W-1:0]) begin
                  dec_acc_reg <= 24'h00_0000;
                  dec_cnt_reg <= {DEC_CNT_W{1'b0}};
                  if (req_reg < max_gain) begin
                    req_reg <= req_reg + 7'h01;
                  end
                end else begin
                  dec_acc_reg <= dec_sum;
                  dec_cnt_reg <= dec_cnt_reg + {{(DEC_CNT_W-1){1'b0}}, 1'b1};
                end
              end else begin
                atk_acc_reg <= 24'h00_0000;
                dec_acc_reg <= 24'h00_0000;
                dec_cnt_reg <= {DEC_CNT_W{1'b0}};
                sat_reg     <= 1'b0;
              end
            end
            ST_GATE: begin
              // step toward 0 dB each sample
              if (req_reg != `RAL_GAIN_ZERO) begin
                req_reg <= req_reg - 7'h01;
              end
              atk_acc_reg <= 24'h00_0000;
              dec_acc_reg <= 24'h00_0000;
              dec_cnt_reg <= {DEC_CNT_W{1'b0}};
              if (i_gate_off[ch]) begin
                state_reg <= ST_RUN;
                noise_reg <= 1'b0;
                deb_reg   <= 4'h0;
              // hold until level clears release point
              end else if (avg > rel) begin
                if (deb_reg >= deb_lim) begin
                  state_reg <= ST_RUN;
                  noise_reg <= 1'b0;
                  deb_reg   <= 4'h0;
                end else begin
                  deb_reg <= deb_reg + 4'h1;
                end
              end else begin
                deb_reg <= 4'h0;
              end
            end
            default: begin
              state_reg <= ST_OFF;
            end
          endcase
        end
      end

      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          app_reg  <= `RAL_GAIN_ZERO;
          mute_reg <= 1'b1;
          half_reg <= 1'b0;
          done_reg <= 1'b0;
        end else if (i_adc_valid) begin
          half_reg <= ~half_reg;
          done_reg <= !mute_reg && (app_reg == req_reg);
          if (!i_step_two || half_reg) begin
            if (mute_reg) begin
              mute_reg <= !en;
            end else if (app_reg < req_reg) begin
              app_reg <= app_reg + 7'h01;
            end else if (app_reg > req_reg) begin
              app_reg <= app_reg - 7'h01;
            end
          end
        end
      end

      assign o_gain_req[7*ch +: 7]     = req_reg;
      assign o_gain_applied[7*ch +: 7] = app_reg;
      assign o_gain_muted[ch]          = mute_reg;
      assign o_gain_done[ch]           = done_reg;
      assign o_noise_flag[ch]          = noise_reg;
      assign o_sat_flag[ch]            = sat_reg;
    end
  endgenerate

endmodule

// File: sim/ral_auto_level_monitor.sv
// Port checker of the stereo record level loop
module ral_auto_level_monitor (
  input logic        i_clk,
  input logic        i_sys_rst,
  input logic [7:0]  i_reg_addr,
  input logic [7:0]  i_reg_wdata,
  input logic        i_reg_wr,
  input logic [7:0]  o_reg_rdata,
  input logic        i_adc_valid,
  input logic [1:0]  i_loop_enable,
  input logic [13:0] i_max_gain,
  input logic [13:0] o_gain_req,
  input logic [13:0] o_gain_applied,
  input logic [1:0]  o_gain_muted,
  input logic [1:0]  o_noise_flag,
  input logic [1:0]  o_sat_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Mapped index window and left gain fields
  wire       mapped = (i_reg_addr >= 8'h67) && (i_reg_addr <= 8'h6A);
  wire [6:0] req_l  = o_gain_req[6:0];
  wire [6:0] app_l  = o_gain_applied[6:0];

  rdata_zero_a: assert property (
    !mapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  wr_back_a: assert property (
    i_reg_wr && mapped ##1 $stable(i_reg_addr) && !i_reg_wr
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("written value not read back");
  rst_mute_a: assert property (disable iff (1'b0)
    i_sys_rst |=> o_gain_muted == 2'h3 && o_gain_req == 14'h0000
    && o_noise_flag == 2'h0)
    else $error("reset state wrong");
  idle_hold_a: assert property (
    !i_adc_valid |=> $stable(o_gain_req) && $stable(o_gain_applied)
    && $stable(o_noise_flag))
    else $error("gain moved without a sample");
  req_step_a: assert property (
    i_adc_valid |=> 7'(req_l - $past(req_l)) inside {7'h00, 7'h01, 7'h7F})
    else $error("requested gain jumped");
  app_step_a: assert property (
    i_adc_valid |=> 7'(app_l - $past(app_l)) inside {7'h00, 7'h01, 7'h7F})
    else $error("applied gain jumped");
  off_hold_a: assert property (
    i_adc_valid && !i_loop_enable[0]
    |=> $stable(req_l) && !o_noise_flag[0] && !o_sat_flag[0])
    else $error("disabled loop changed gain");
  cap_keep_a: assert property (
    i_adc_valid && req_l <= i_max_gain[6:0]
    |=> req_l <= $past(i_max_gain[6:0]))
    else $error("gain above cap");
  gate_down_a: assert property (
    i_adc_valid && o_noise_flag[0]
    |=> req_l <= $past(req_l) || !o_noise_flag[0])
    else $error("gain rose while gated");

  cover property (i_adc_valid && o_sat_flag == 2'h3);
  cover property ($rose(o_noise_flag[0]));
  cover property (i_reg_wr && mapped);
endmodule

// File: sim/ral_adc_src.sv
// ADC sample source behind the input gain amplifier
module ral_adc_src (
  input  logic        i_clk,
  input  logic        i_sys_rst,
  input  logic [15:0] i_amp_l,
  input  logic [15:0] i_amp_r,
  input  logic [13:0] i_gain,
  output logic        o_valid,
  output logic [15:0] o_left,
  output logic [15:0] o_right
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  logic       neg_reg;

  // Amplitude doubled per 12 gain codes, sign set
  function automatic logic [15:0] lvl(logic [15:0] a, logic [6:0] g,
                                      logic n);
    logic [15:0] v;
    v = a << (g / 7'd12);
    lvl = n ? -v : v;
  endfunction

  // One sample each fourth cycle, data churns between samples
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= 2'h0;
      neg_reg <= 1'b0;
      o_valid <= 1'b0;
      o_left  <= 16'h0000;
      o_right <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      o_valid <= (cnt_reg == 2'h3);
      if (cnt_reg == 2'h3) begin
        neg_reg <= ~neg_reg;
        o_left  <= lvl(i_amp_l, i_gain[6:0], neg_reg);
        o_right <= lvl(i_amp_r, i_gain[13:7], neg_reg);
      end else begin
        o_left  <= ~o_left;
        o_right <= ~o_right;
      end
    end
  end
endmodule

// File: sim/ral_auto_level_tb.sv
// Self-checking bench of the stereo record level loop
module ral_auto_level_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; int sel; logic [13:0] ex;} ral_note_t;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, look = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, deb = 8'h00;
  logic [1:0]  en = 2'h0, gate_off = 2'h0;
  logic [3:0]  hys = 4'h0;
  logic [5:0]  tgt = 6'h3F;
  logic        two = 1'b0;
  logic [13:0] max_g = 14'h0000;
  logic [15:0] amp_l = 16'h0000, amp_r = 16'h0000;
  logic [16:0] lfsr = 17'h115C7;
  wire         valid;
  wire  [7:0]  rdata;
  wire  [15:0] adc_l, adc_r;
  wire  [13:0] req, app;
  wire  [1:0]  muted, nflag, sflag, done;
  int          n_fail = 0, checked = 0;
  ral_note_t   q[$];

  // Half period of 5 ns
  always #5 i_clk = ~i_clk;

  ral_auto_level #(.AVG_SHIFT(2), .DEC_CNT_MAX(20)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_reg_rdata(rdata),
    .i_adc_valid(valid), .i_adc_left(adc_l), .i_adc_right(adc_r),
    .i_loop_enable(en), .i_target_sel(tgt), .i_max_gain(max_g),
    .i_noise_sel(8'h00), .i_gate_off(gate_off), .i_debounce(deb),
    .i_hyst_sel(hys), .i_step_two(two), .i_reference_sample_rate(6'h01),
    .i_adc_rate_divider(4'h0), .o_gain_req(req), .o_gain_applied(app),
    .o_gain_muted(muted), .o_gain_done(done), .o_noise_flag(nflag),
    .o_sat_flag(sflag));

  ral_adc_src u_src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_amp_l(amp_l),
    .i_amp_r(amp_r), .i_gain(app), .o_valid(valid), .o_left(adc_l),
    .o_right(adc_r));

  // Next pseudo random value
  function automatic logic [16:0] nxt(logic [16:0] s);
    nxt = {s[15:0], s[16] ^ s[13]};
  endfunction

  // Queue an expectation and flag it for the watcher
  task automatic note(string nm, int sel, logic [13:0] ex);
    q.push_back('{nm, sel, ex});
    look <= 1'b1;
    @(posedge i_clk);
    look <= 1'b0;
    @(posedge i_clk);
  endtask

  // Register write with one-cycle strobe
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Register read, data due one edge after the index
  task automatic reg_rd(logic [7:0] a, logic [7:0] ex);
    i_reg_addr <= a;
    @(posedge i_clk);
    note("rdata", 0, {6'h00, ex});
  endtask

  // Let a number of samples pass
  task automatic run(int n);
    repeat (n) @(posedge valid);
    @(posedge i_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare the oldest note with the output it names
  always @(negedge i_clk) begin
    if (look) begin
      ral_note_t   n;
      logic [13:0] got;
      n = q.pop_front();
      case (n.sel)
        0: got = {6'h00, rdata};
        1: got = req;
        2: got = app;
        3: got = {12'h000, muted};
        4: got = {12'h000, nflag};
        5: got = {12'h000, sflag};
        default: got = {12'h000, done};
      endcase
      checked++;
      if (got !== n.ex) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", n.nm, n.ex, got);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    for (int a = 8'h67; a <= 8'h6A; a++) reg_rd(a[7:0], 8'h00);
    note("muted", 3, 14'h0003);
    note("req", 1, 14'h0000);
    $display("test reset done");
    // Random codes, edges of the map refused
    for (int a = 8'h66; a <= 8'h6B; a++) begin
      lfsr = nxt(lfsr);
      reg_wr(a[7:0], lfsr[7:0]);
      reg_rd(a[7:0], (a < 8'h67 || a > 8'h6A) ? 8'h00 : lfsr[7:0]);
    end
    for (int a = 8'h67; a <= 8'h6A; a++) reg_wr(a[7:0], 8'h00);
    $display("test registers done");
    // quiet input kept well below the -24 dB target
    max_g <= {7'd6, 7'd10};
    amp_l <= 16'd1500;
    amp_r <= 16'd1500;
    run(40);
    note("req off", 1, 14'h0000);
    note("muted off", 3, 14'h0003);
    en <= 2'h3;
    run(150);
    note("req cap", 1, {7'd6, 7'd10});
    note("app cap", 2, {7'd6, 7'd10});
    note("sat", 5, 14'h0003);
    note("muted", 3, 14'h0000);
    note("done cap", 6, 14'h0003);
    // Attack with the applied gain stepping every second sample
    two <= 1'b1;
    amp_l <= 16'd12000;
    run(40);
    note("req attack", 1, {7'd6, 7'd0});
    note("sat attack", 5, 14'h0002);
    note("app attack", 2, {7'd6, 7'd0});
    $display("test loop done");
    amp_l <= 16'd1500;
    run(80);
    amp_l <= 16'd100;
    run(40);
    note("noise flag", 4, 14'h0001);
    note("req gated", 1, {7'd6, 7'd0});
    // applied gain and saturation status not judged while gated
    hys <= 4'h1;
    amp_l <= 16'd1500;
    run(20);
    note("noise held", 4, 14'h0001);
    hys <= 4'h0;
    run(80);
    note("noise clear", 4, 14'h0000);
    note("req ungated", 1, {7'd6, 7'd10});
    amp_l <= 16'd100;
    gate_off <= 2'h1;
    run(80);
    note("gate off", 4, 14'h0000);
    note("req no gate", 1, {7'd6, 7'd10});
    $display("test gate done");
    en <= 2'h0;
    run(8);
    note("req parked", 1, {7'd6, 7'd10});
    note("sat parked", 5, 14'h0000);
    $display("test disable done");
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    note("muted rst", 3, 14'h0003);
    note("req rst", 1, 14'h0000);
    i_sys_rst <= 1'b0;
    run(4);
    note("muted idle", 3, 14'h0003);
    $display("test second reset done");
    wrap_up();
  end
endmodule

bind ral_auto_level ral_auto_level_monitor u_mon (.i_clk, .i_sys_rst,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .o_reg_rdata, .i_adc_valid,
  .i_loop_enable, .i_max_gain, .o_gain_req, .o_gain_applied,
  .o_gain_muted, .o_noise_flag, .o_sat_flag);
